// ### vic_pkg.sv
// constants, field layouts and state carrier of the vectored interrupt controller
// assumes one core clock domain and the core reset shared with the cpu
`default_nettype none
package vic_pkg;
  localparam int          NUM_TRAPS      = 4;              // processor trap sources
  localparam int          FIRST_IRQ_VEC  = 8;              // vector of the first interrupt
  localparam int          LAST_IRQ_VEC   = 125;            // last vector slot in the table
  localparam int          NUM_IRQ        = LAST_IRQ_VEC - FIRST_IRQ_VEC + 1;
  localparam int          TRAP_FIRST_VEC = 1;              // trap slots sit below the irqs
  localparam int          VEC_W          = 7;              // vector number width
  localparam int          ADDR_W         = 24;             // program address width
  localparam int          LVL_W          = 4;              // level incl. trap level
  localparam int          PRIO_W         = 3;              // user priority field
  localparam int          STACK_DEPTH    = 8;              // nested handler depth
  localparam int          SP_W           = 4;              // stack pointer width
  localparam int          DIS_CNT_W      = 14;             // timed disable counter width
  localparam logic [ADDR_W-1:0] TABLE_BASE   = 24'h000004; // start of primary table
  localparam logic [ADDR_W-1:0] ALT_OFFSET   = 24'h000100; // alternate table distance
  localparam logic [LVL_W-1:0]  LVL_MAX_USER = 4'h7;       // highest user level
  localparam logic [LVL_W-1:0]  LVL_TRAP     = 4'h8;       // traps above every irq
  localparam logic [LVL_W-1:0]  LVL_DIS_TOP  = 4'h6;       // timed disable covers 6 and below
  localparam logic [LVL_W-1:0]  LVL_OFF      = 4'h0;       // level 0 disables a source
  localparam logic [PRIO_W-1:0] CPL_RESET    = 3'h0;       // core level after reset
  localparam logic [SP_W-1:0]   SP_FULL      = 4'h8;       // stack holds STACK_DEPTH
  // reserved vector slots that are never requested
  localparam logic [VEC_W-1:0]  RSV_VEC_A    = 7'h17;      // vector 23
  localparam logic [VEC_W-1:0]  RSV_VEC_B    = 7'h1A;      // vector 26
  localparam logic [VEC_W-1:0]  RSV_VEC_C    = 7'h35;      // vector 53
  localparam logic [VEC_W-1:0]  RSV_VEC_D    = 7'h4B;      // vector 75
  localparam logic [VEC_W-1:0]  RSV_FROM     = 7'h50;      // vectors 80 and up
  // named vectors of the fixed peripherals
  localparam logic [VEC_W-1:0]  VEC_EXTERNAL_IRQ_0     = 7'h08;
  localparam logic [VEC_W-1:0]  VEC_DMA_CHANNEL_0_IRQ  = 7'h0C;
  localparam logic [VEC_W-1:0]  VEC_SPI1_ERROR_IRQ     = 7'h11;
  localparam logic [VEC_W-1:0]  VEC_SPI1_DONE_IRQ      = 7'h12;
  localparam logic [VEC_W-1:0]  VEC_SERIAL1_RX_IRQ     = 7'h13;
  localparam logic [VEC_W-1:0]  VEC_SERIAL1_TX_IRQ     = 7'h14;
  localparam logic [VEC_W-1:0]  VEC_CONVERTER_1_IRQ    = 7'h15;
  localparam logic [VEC_W-1:0]  VEC_DMA_CHANNEL_1_IRQ  = 7'h16;
  localparam logic [VEC_W-1:0]  VEC_TWOWIRE1_DONE_IRQ  = 7'h18;
  localparam logic [VEC_W-1:0]  VEC_TWOWIRE1_COLL_IRQ  = 7'h19;
  localparam logic [VEC_W-1:0]  VEC_PIN_CHANGE_IRQ     = 7'h1B;
  localparam logic [VEC_W-1:0]  VEC_EXTERNAL_IRQ_1     = 7'h1C;
  localparam logic [VEC_W-1:0]  VEC_CONVERTER_2_IRQ    = 7'h1D;
  localparam logic [VEC_W-1:0]  VEC_DMA_CHANNEL_2_IRQ  = 7'h20;
  localparam logic [VEC_W-1:0]  VEC_EXTERNAL_IRQ_2     = 7'h25;
  localparam logic [VEC_W-1:0]  VEC_SERIAL2_RX_IRQ     = 7'h26;
  localparam logic [VEC_W-1:0]  VEC_SERIAL2_TX_IRQ     = 7'h27;

  // request presented to the core
  typedef struct packed {
    logic              valid;   // request pending toward core
    logic              trap;    // winner is a trap
    logic [VEC_W-1:0]  vector;  // winning vector number
    logic [ADDR_W-1:0] addr;    // table entry address to fetch
    logic [LVL_W-1:0]  level;   // level of the winner
  } core_req_t;

  // whole controller state
  typedef struct packed {
    logic [NUM_IRQ-1:0]                  flags;      // per-source status flags
    core_req_t                           req;        // registered request
    logic [PRIO_W-1:0]                   cpl;        // core priority level
    logic [STACK_DEPTH-1:0][PRIO_W-1:0]  stack;      // saved levels of nested handlers
    logic [SP_W-1:0]                     sp;         // stack fill
    logic [DIS_CNT_W-1:0]                dis_cnt;    // remaining disabled cycles
    logic                                dis_active; // timed disable running
  } vic_state_t;
endpackage
`default_nettype wire

// ### vectored_interrupt_controller.sv
// vectored interrupt controller: flags, enables, priorities, arbitration, vector address
// assumes peripherals give one-cycle or level requests, and the core acks the shown request
// assumes software clears a served flag; the core's take leaves it set
//
// Behaviour
// - arbitrate four traps and all interrupt sources
// - primary vector table starts at program address 0x000004, alternate at 0x000104
// - each source: own vector, enable, priority
// - each source keeps its own status flag
// - enable and priority applied centrally before core
// - timed disable blocks levels six and below
// - external irq 0 uses vector eight
// - dma channels 0..2 use vectors 12,22,32
// - serial1 rx/tx use vectors 19,20
// - serial2 rx/tx use vectors 38,39
// - twowire1 done/collision use vectors 24,25
// - pin change uses vector 27
// - converters use vectors 21 and 29
// - external irq 1,2 use vectors 28,37
// - levels 0..7, 7 highest, 0 off
// - equal level: lower vector wins
// - nesting disabled forces level 7, cpl read-only
`default_nettype none
module vectored_interrupt_controller
  import vic_pkg::*;
(
  input  wire logic                              i_clk_sys,       // core clock
  input  wire logic                              i_rst_n,         // async reset, active low
  input  wire logic [NUM_TRAPS-1:0]              i_trap_req,      // trap levels
  input  wire logic [NUM_IRQ-1:0]                i_irq_req,       // source requests, vec 8 up
  input  wire logic [NUM_IRQ-1:0]                i_flag_clr,      // software flag clears
  input  wire logic [NUM_IRQ-1:0]                i_irq_en,        // software enables
  input  wire logic [NUM_IRQ-1:0][PRIO_W-1:0]    i_irq_prio,      // software priorities
  input  wire logic                              i_alt_table_sel, // use alternate table
  input  wire logic                              i_nesting_disable_bit, // no nesting
  input  wire logic                              i_cpl_wr,        // write core level
  input  wire logic [PRIO_W-1:0]                 i_cpl_wdata,     // new core level
  input  wire logic                              i_core_ack,      // core takes request
  input  wire logic                              i_return_from_handler, // handler exit
  input  wire logic                              i_timed_irq_disable,   // start timed disable
  input  wire logic [DIS_CNT_W-1:0]              i_disable_count, // cycles to disable
  input  wire logic                              i_instr_cycle,   // one instruction done
  output logic [NUM_IRQ-1:0]                     o_irq_flag,      // status flags
  output logic                                   o_req_valid,     // request to core
  output logic                                   o_req_trap,      // request is a trap
  output logic [VEC_W-1:0]                       o_req_vector,    // winning vector
  output logic [ADDR_W-1:0]                      o_req_addr,      // entry to fetch
  output logic [LVL_W-1:0]                       o_req_level,     // winner level
  output logic [PRIO_W-1:0]                      o_core_priority_level, // current level
  output logic                                   o_disable_active // timed disable running
);

  // one packed struct carries every flip-flop of the block
  vic_state_t state_reg;  // all state
  vic_state_t state_next; // its next value

  // reserved slots must never reach the core, even if a peripheral pin toggles
  // folds to constants per slot, so it costs no gates at run time
  function automatic logic is_reserved(input logic [VEC_W-1:0] vec);
    is_reserved = (vec == RSV_VEC_A) || (vec == RSV_VEC_B) || (vec == RSV_VEC_C) ||
                  (vec == RSV_VEC_D) || (vec >= RSV_FROM);
  endfunction

  // table entry address of a vector, primary or alternate
  // entries are two words apart, hence the shift by one
  function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_W-1:0] vec,
                                                 input logic             alt);
    logic [ADDR_W-1:0] a;
    a = TABLE_BASE + {{(ADDR_W-VEC_W-1){1'b0}}, vec, 1'b0};
    vec_addr = alt ? (a + ALT_OFFSET) : a;
  endfunction

  // source index to vector number; fixed mapping keeps each peripheral on its slot
  // bit i of the request bus is vector i plus the first irq slot
  function automatic logic [VEC_W-1:0] idx_vec(input int idx);
    idx_vec = VEC_W'(idx + FIRST_IRQ_VEC);
  endfunction

  // reserved mask built once, from constants only
  // masked slots fold to zero flags and are trimmed away
  logic [NUM_IRQ-1:0] live_mask; // sources that exist
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : gen_mask
      assign live_mask[g] = !is_reserved(idx_vec(g));
    end
  endgenerate

  // arbitration and next state
  // one pass: flags, winner search, core level, timed disable
  always_comb
  begin
    logic [LVL_W-1:0]  best_lvl;
    logic [VEC_W-1:0]  best_vec;
    logic              best_hit;
    logic              best_trap;
    logic [LVL_W-1:0]  lvl;
    logic [LVL_W-1:0]  cpl_lvl;
    logic              blocked;
    best_lvl  = LVL_OFF;
    best_vec  = '0;
    best_hit  = 1'b0;
    best_trap = 1'b0;
    lvl       = LVL_OFF;
    blocked   = 1'b0;
    // defaults keep every path assigned, so no latch is inferred
    state_next = state_reg;
    cpl_lvl   = {1'b0, state_reg.cpl};

    // sticky flags: a new request beats a same-cycle clear
    state_next.flags = ((state_reg.flags & ~i_flag_clr) | i_irq_req) & live_mask;

    // scan high vector to low with >=, so lower vector wins ties
    // a disabled, blocked or off source simply never competes
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      lvl     = {1'b0, i_irq_prio[i]};
      blocked = state_reg.dis_active && (lvl <= LVL_DIS_TOP);
      if (state_reg.flags[i] && i_irq_en[i] && live_mask[i] && (lvl != LVL_OFF) &&
          !blocked && (lvl >= best_lvl))
      begin
        best_lvl = lvl;
        best_vec = idx_vec(i);
        best_hit = 1'b1;
      end
    end
    // traps sit above every user level; lowest trap slot wins
    // trap inputs are levels and are not latched here
    for (int t = NUM_TRAPS - 1; t >= 0; t--)
    begin
      if (i_trap_req[t])
      begin
        best_lvl  = LVL_TRAP;
        best_vec  = VEC_W'(t + TRAP_FIRST_VEC);
        best_hit  = 1'b1;
        best_trap = 1'b1;
      end
    end

    // present only what outranks the core; drop it in the ack cycle so it is not taken twice
    // the request register costs a cycle but keeps the core's inputs glitch free
    state_next.req.valid  = best_hit && (best_lvl > cpl_lvl) && !i_core_ack;
    state_next.req.trap   = best_trap;
    state_next.req.vector = best_vec;
    state_next.req.addr   = vec_addr(best_vec, i_alt_table_sel);
    state_next.req.level  = best_lvl;

    // handler entry, exit and software level writes
    // entry beats return, and both beat a software write in one cycle
    if (i_core_ack && state_reg.req.valid)
    begin
      // push the interrupted level before raising it
      if (state_reg.sp != SP_FULL) // saturate instead of overwriting saved levels
      begin
        state_next.stack[state_reg.sp[SP_W-2:0]] = state_reg.cpl;
        state_next.sp = state_reg.sp + 1'b1;
      end
      // trap entry, or any entry with nesting off, masks every user level
      if (i_nesting_disable_bit || state_reg.req.trap)
        state_next.cpl = LVL_MAX_USER[PRIO_W-1:0];
      else
        state_next.cpl = state_reg.req.level[PRIO_W-1:0];
    end
    else if (i_return_from_handler && (state_reg.sp != '0))
    begin
      // restore the level saved at entry; an empty stack ignores the return
      state_next.cpl = state_reg.stack[state_reg.sp[SP_W-2:0] - 1'b1];
      state_next.sp  = state_reg.sp - 1'b1;
    end
    else if (i_cpl_wr && !i_nesting_disable_bit)
    begin
      state_next.cpl = i_cpl_wdata;
    end

    // timed disable: a new start reloads, otherwise count instruction cycles
    // a start with a zero count ends any running disable at once
    if (i_timed_irq_disable)
    begin
      state_next.dis_cnt    = i_disable_count;
      state_next.dis_active = (i_disable_count != '0);
    end
    else if (state_reg.dis_active && i_instr_cycle)
    begin
      state_next.dis_cnt    = state_reg.dis_cnt - 1'b1;
      state_next.dis_active = (state_reg.dis_cnt != DIS_CNT_W'(1));
    end
  end

  // state register
  // reset clears flags, request, stack and disable; level starts at its reset value
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg       <= '0;
      state_reg.cpl   <= CPL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  // no logic behind the register, so outputs settle right after the edge
  assign o_irq_flag            = state_reg.flags;
  assign o_req_valid           = state_reg.req.valid;
  assign o_req_trap            = state_reg.req.trap;
  assign o_req_vector          = state_reg.req.vector;
  assign o_req_addr            = state_reg.req.addr;
  assign o_req_level           = state_reg.req.level;
  assign o_core_priority_level = state_reg.cpl;
  assign o_disable_active      = state_reg.dis_active;

endmodule
`default_nettype wire

// ### vic_asserts.sv
// port checker of the vectored interrupt controller
// assumes one core clock domain and the async core reset
`default_nettype none
module vic_asserts
  import vic_pkg::*;
(
  input wire logic                 i_clk_sys,             // core clock
  input wire logic                 i_rst_n,               // reset, low
  input wire logic [NUM_IRQ-1:0]   i_irq_req,             // requests
  input wire logic [NUM_IRQ-1:0]   i_flag_clr,            // clears
  input wire logic                 i_core_ack,            // core take
  input wire logic                 i_nesting_disable_bit, // no nesting
  input wire logic                 i_timed_irq_disable,   // disable start
  input wire logic [DIS_CNT_W-1:0] i_disable_count,       // disable length
  input wire logic [NUM_IRQ-1:0]   o_irq_flag,            // flags
  input wire logic                 o_req_valid,           // request
  input wire logic                 o_req_trap,            // trap request
  input wire logic [VEC_W-1:0]     o_req_vector,          // vector
  input wire logic [ADDR_W-1:0]    o_req_addr,            // entry
  input wire logic [LVL_W-1:0]     o_req_level,           // level
  input wire logic [PRIO_W-1:0]    o_core_priority_level, // core level
  input wire logic                 o_disable_active       // disable busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // core takes the shown request this cycle
  sequence s_taken;
    o_req_valid && i_core_ack;
  endsequence
  a_flag_set: assert property (i_irq_req[0] |=> o_irq_flag[0])
    else $error("flag of vector 8 not set");
  a_flag_clear: assert property (i_flag_clr[0] && !i_irq_req[0] |=> !o_irq_flag[0])
    else $error("flag of vector 8 not cleared");
  // reserved slots 23 and 26 must stay silent
  a_rsv_silent: assert property (!o_irq_flag[15] && !o_irq_flag[18])
    else $error("reserved vector flag set");
  a_addr_map: assert property (o_req_valid |->
    o_req_addr[7:0] == {o_req_vector, 1'b0} + 8'h04 && o_req_addr[23:9] == '0)
    else $error("entry address not base plus twice vector");
  a_trap_level: assert property (o_req_valid && o_req_trap |->
    o_req_level == LVL_TRAP && o_req_vector inside {[1:4]})
    else $error("trap request with wrong level or vector");
  a_above_core: assert property (o_req_valid && !o_req_trap |->
    o_req_level > {1'b0, $past(o_core_priority_level)})
    else $error("request not above core level");
  a_dis_block: assert property (o_req_valid && !o_req_trap && $past(o_disable_active) |->
    o_req_level == 4'h7)
    else $error("level six or below passed timed disable");
  a_dis_start: assert property (i_timed_irq_disable && i_disable_count != '0 |=>
    o_disable_active)
    else $error("timed disable not active");
  a_ack_drop: assert property (s_taken |=> !o_req_valid)
    else $error("request kept after core take");
  a_ack_level: assert property (s_taken ##0 (!i_nesting_disable_bit && !o_req_trap) |=>
    {1'b0, o_core_priority_level} == $past(o_req_level))
    else $error("core level not raised to taken level");
  a_nest_seven: assert property (s_taken ##0 i_nesting_disable_bit |=>
    o_core_priority_level == 3'h7)
    else $error("nesting disabled entry not at level 7");
endmodule
bind vectored_interrupt_controller vic_asserts i_vic_asserts (
  .i_clk_sys, .i_rst_n, .i_irq_req, .i_flag_clr, .i_core_ack, .i_nesting_disable_bit,
  .i_timed_irq_disable, .i_disable_count, .o_irq_flag, .o_req_valid, .o_req_trap,
  .o_req_vector, .o_req_addr, .o_req_level, .o_core_priority_level, .o_disable_active
);
`default_nettype wire

// ### cpu_core_model.sv
// behavioural core that takes the controller's requests
// assumes requests are registered on the core clock
`default_nettype none
module cpu_core_model
(
  input  wire logic i_clk_sys,   // core clock
  input  wire logic i_rst_n,     // reset, active low
  input  wire logic i_req_valid, // request shown
  input  wire logic i_ack_en,    // bench lets the core take
  input  wire logic i_slow,      // wait one more cycle first
  output logic      o_core_ack   // one-cycle take pulse
);
  logic wait_reg; // slow take has waited once
  // take the shown request with a one-cycle ack pulse, one cycle later when slow
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core_ack <= 1'b0;
      wait_reg   <= 1'b0;
    end
    else
    begin
      o_core_ack <= 1'b0;
      // no second pulse while the first is still seen
      if (i_req_valid && i_ack_en && !o_core_ack)
      begin
        wait_reg   <= i_slow && !wait_reg;
        o_core_ack <= !i_slow || wait_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ### vectored_interrupt_controller_bench.sv
// self-checking bench of the vectored interrupt controller
// assumes the core model takes requests only when allowed
`default_nettype none
module vectored_interrupt_controller_bench
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           i_clk_sys = 1'b0, i_rst_n = 1'b0;
  logic [NUM_TRAPS-1:0]           i_trap_req = '0;
  logic [NUM_IRQ-1:0]             i_irq_req = '0, i_flag_clr = '0, i_irq_en = '0;
  logic [NUM_IRQ-1:0][PRIO_W-1:0] i_irq_prio = '0;
  logic i_alt_table_sel = 1'b0, i_nesting_disable_bit = 1'b0, i_cpl_wr = 1'b0;
  logic i_return_from_handler = 1'b0, i_timed_irq_disable = 1'b0, i_instr_cycle = 1'b0;
  logic [PRIO_W-1:0]    i_cpl_wdata = '0;
  logic [DIS_CNT_W-1:0] i_disable_count = '0;
  logic i_core_ack, ack_en = 1'b0, slow = 1'b0, o_req_valid, o_req_trap, o_disable_active;
  logic [NUM_IRQ-1:0] o_irq_flag;
  logic [VEC_W-1:0]   o_req_vector;
  logic [ADDR_W-1:0]  o_req_addr;
  logic [LVL_W-1:0]   o_req_level;
  logic [PRIO_W-1:0]  o_core_priority_level;
  int err_total = 0, total_checks = 0;
  // entry addresses of the named sources, primary table
  logic [7:0] tab [17] = '{8'h14, 8'h1C, 8'h30, 8'h44, 8'h2A, 8'h2C, 8'h50, 8'h52, 8'h34,
                           8'h36, 8'h26, 8'h28, 8'h3A, 8'h2E, 8'h3E, 8'h3C, 8'h4E};
  vectored_interrupt_controller i_vectored_interrupt_controller (
    .i_clk_sys, .i_rst_n, .i_trap_req, .i_irq_req, .i_flag_clr, .i_irq_en, .i_irq_prio,
    .i_alt_table_sel, .i_nesting_disable_bit, .i_cpl_wr, .i_cpl_wdata, .i_core_ack,
    .i_return_from_handler, .i_timed_irq_disable, .i_disable_count, .i_instr_cycle,
    .o_irq_flag, .o_req_valid, .o_req_trap, .o_req_vector, .o_req_addr, .o_req_level,
    .o_core_priority_level, .o_disable_active);
  cpu_core_model i_cpu_core_model (.i_clk_sys, .i_rst_n, .i_req_valid(o_req_valid),
    .i_ack_en(ack_en), .i_slow(slow), .o_core_ack(i_core_ack));
  always #12.5 i_clk_sys = ~i_clk_sys;
  task automatic tk(int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (e !== g)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for a shown request
  task automatic wait_req();
    int n;
    n = 0;
    do
    begin
      tk(1);
      #1;
      n++;
      if (n > 40)
      begin
        err_total++;
        finish_test();
      end
    end
    while (o_req_valid !== 1'b1);
  endtask
  task automatic raise(int i, logic [2:0] p);
    i_irq_en[i] <= 1'b1;
    i_irq_prio[i] <= p;
    i_irq_req[i] <= 1'b1;
    tk(1);
    i_irq_req[i] <= 1'b0;
  endtask
  task automatic clear_all();
    tk(1);
    i_flag_clr <= '1;
    i_irq_en <= '0;
    tk(2);
    i_flag_clr <= '0;
  endtask
  task automatic t_walk();
    raise(0, 3'h3);
    #1;
    chk("flag", 1'b1, o_irq_flag[0]);
    tk(1);
    #1;
    chk("addr", 24'h000014, o_req_addr);
    tk(1);
    ack_en <= 1'b1;
    tk(4);
    #1;
    chk("held", 1'b0, o_req_valid);
    chk("level", 3'h3, o_core_priority_level);
    tk(1);
    ack_en <= 1'b0;
    i_flag_clr[0] <= 1'b1;
    tk(1);
    i_flag_clr[0] <= 1'b0;
    i_return_from_handler <= 1'b1;
    #1;
    chk("cleared", 1'b0, o_irq_flag[0]);
    tk(1);
    i_return_from_handler <= 1'b0;
    #1;
    chk("popped", 3'h0, o_core_priority_level);
    clear_all();
  endtask
  // every named source, alternate table on every other one
  task automatic t_table();
    for (int k = 0; k < 17; k++)
    begin
      i_alt_table_sel <= ~k[0];
      raise((tab[k] - 4) / 2 - 8, 3'h7);
      wait_req();
      chk("vector", (tab[k] - 8'h04) >> 1, o_req_vector);
      chk("entry", {15'h0, ~k[0], tab[k]}, o_req_addr);
      clear_all();
    end
    // later scenarios expect primary table entries
    i_alt_table_sel <= 1'b0;
  endtask
  task automatic t_prio();
    i_irq_en[0] <= 1'b1;
    i_irq_prio[0] <= 3'h0;
    i_irq_prio[1] <= 3'h7;
    i_irq_en[9] <= 1'b1;
    i_irq_prio[9] <= 3'h2;
    i_irq_en[20] <= 1'b1;
    i_irq_prio[20] <= 3'h5;
    i_irq_en[29] <= 1'b1;
    i_irq_prio[29] <= 3'h5;
    i_irq_req <= '1;
    tk(1);
    i_irq_req <= '0;
    wait_req();
    chk("winner", 7'h1C, o_req_vector);
    chk("win level", 4'h5, o_req_level);
    chk("reserved", 1'b0, o_irq_flag[15]);
    clear_all();
  endtask
  task automatic t_disable();
    i_timed_irq_disable <= 1'b1;
    i_disable_count <= 14'h0003;
    i_irq_en[0] <= 1'b1;
    i_irq_prio[0] <= 3'h6;
    i_irq_en[20] <= 1'b1;
    i_irq_prio[20] <= 3'h7;
    i_irq_req[0] <= 1'b1;
    i_irq_req[20] <= 1'b1;
    tk(1);
    i_timed_irq_disable <= 1'b0;
    i_irq_req <= '0;
    wait_req();
    chk("seven passes", 7'h1C, o_req_vector);
    tk(1);
    i_flag_clr[20] <= 1'b1;
    tk(1);
    i_flag_clr[20] <= 1'b0;
    tk(2);
    #1;
    chk("six blocked", 1'b0, o_req_valid);
    tk(1);
    i_instr_cycle <= 1'b1;
    tk(2);
    #1;
    chk("still off", 1'b1, o_disable_active);
    tk(1);
    i_instr_cycle <= 1'b0;
    #1;
    chk("disable done", 1'b0, o_disable_active);
    wait_req();
    chk("six after", 7'h08, o_req_vector);
    clear_all();
  endtask
  task automatic t_nest();
    i_nesting_disable_bit <= 1'b1;
    ack_en <= 1'b1;
    slow <= 1'b1;
    raise(0, 3'h2);
    wait_req();
    tk(3);
    #1;
    chk("nest level", 3'h7, o_core_priority_level);
    tk(1);
    ack_en <= 1'b0;
    i_cpl_wr <= 1'b1;
    tk(1);
    i_cpl_wr <= 1'b0;
    #1;
    chk("level locked", 3'h7, o_core_priority_level);
    clear_all();
    i_trap_req <= 4'h2;
    i_nesting_disable_bit <= 1'b0;
    wait_req();
    chk("trap", 1'b1, o_req_trap);
    chk("trap vec", 7'h02, o_req_vector);
    chk("trap addr", 24'h000008, o_req_addr);
    tk(1);
    i_trap_req <= '0;
    clear_all();
    // with nesting on again a software level write lands
    i_cpl_wdata <= 3'h5;
    i_cpl_wr <= 1'b1;
    tk(1);
    i_cpl_wr <= 1'b0;
    #1;
    chk("level write", 3'h5, o_core_priority_level);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_walk();
    t_table();
    t_prio();
    t_disable();
    t_nest();
    finish_test();
  end
endmodule
`default_nettype wire
